// ===== verilog/tws_slave.sv
// Operation
// - Receiver acknowledges every byte; device acks each accepted byte.
// - First byte after START is address; upper seven bits are target.
// - Address LSB one: device transmits; zero: device receives.
// - On match, acknowledge address and become transmitter or receiver.
// - Respond only to seven-bit slave address 0x58.
// - Received register address selects the register a byte reaches.
// - Write: address, register address, data, each acked, then STOP.
// - Read: set register address, restart, read address, send byte.
// - START is SDA fall with SCL high; STOP is SDA rise.
// - Bytes are eight bits MSB first; SDA changes only while SCL low.
// - Device is a slave transceiver supporting up to 100 kbit/s.
`timescale 1ns/1ps
`default_nettype none
module tws_slave (
   input  wire logic       clk_in,
   input  wire logic       arst_n_in,
   input  wire logic       link_clk_in,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe_n_out,
   output logic            reg_wr_out,
   output logic            reg_rd_out,
   output logic [7:0]      reg_addr_out,
   output logic [7:0]      reg_wdata_out,
   input  wire logic [7:0] reg_rdata_in
);

   // ------------------------------------------------------------------
   // Link domain: reset release and pin sampling
   // ------------------------------------------------------------------
   logic                link_rst_n;
   logic [1:0]          bus_s;
   logic                scl_s;
   logic                sda_s;
   logic                scl_q;
   logic                sda_q;
   logic                start;
   logic                stop;
   logic                rise;
   logic                fall;
   logic                match;
   tws_pkg::tws_state_t state;
   tws_pkg::tws_state_t ack_next;
   logic [3:0]          cnt;
   logic [7:0]          shift;
   logic [7:0]          reg_ptr;
   logic [7:0]          wr_addr;
   logic [7:0]          wr_data;
   logic [7:0]          rd_addr;
   logic [7:0]          tx_data;
   logic                wr_tgl;
   logic                rd_tgl;
   logic                sda_oe_n;
   logic                ack_tgl_s;
   logic                ack_tgl_q;
   logic [1:0]          req_s;
   logic [1:0]          req_q;
   logic                rd_pending;
   logic                rd_ack_tgl;
   logic [7:0]          rd_hold;

   tws_sync #(.W(1)) u_link_rst (
      .clk_in    (link_clk_in),
      .arst_n_in (arst_n_in),
      .d_in      (1'b1),
      .q_out     (link_rst_n)
   );

   // Sampling at the link clock keeps a wide margin over a 100 kbit/s bus.
   // bus sampling
   tws_sync #(.W(2)) u_bus_sync (
      .clk_in    (link_clk_in),
      .arst_n_in (link_rst_n),
      .d_in      ({scl_in, sda_in}),
      .q_out     (bus_s)
   );

   assign scl_s = bus_s[1];
   assign sda_s = bus_s[0];

   always_ff @(posedge link_clk_in or negedge link_rst_n) begin
      if (!link_rst_n) begin
         scl_q <= 1'b0;
         sda_q <= 1'b0;
      end else begin
         scl_q <= scl_s;
         sda_q <= sda_s;
      end
   end

   assign start = scl_s & scl_q & sda_q & ~sda_s;
   assign stop  = scl_s & scl_q & ~sda_q & sda_s;
   assign rise  = scl_s & ~scl_q;
   assign fall  = ~scl_s & scl_q;
   assign match = (shift[7:1] == tws_pkg::SLAVE_ADDR);

   // ------------------------------------------------------------------
   // Link domain: slave state machine
   // ------------------------------------------------------------------
   always_ff @(posedge link_clk_in or negedge link_rst_n) begin
      if (!link_rst_n) begin
         state    <= tws_pkg::ST_IDLE;
         ack_next <= tws_pkg::ST_IDLE;
         cnt      <= tws_pkg::BIT_CNT_RST;
         shift    <= tws_pkg::BYTE_RST;
         reg_ptr  <= tws_pkg::BYTE_RST;
         wr_addr  <= tws_pkg::BYTE_RST;
         wr_data  <= tws_pkg::BYTE_RST;
         rd_addr  <= tws_pkg::BYTE_RST;
         wr_tgl   <= 1'b0;
         rd_tgl   <= 1'b0;
         sda_oe_n <= 1'b1;
      end else if (start) begin
         state    <= tws_pkg::ST_ADDR;
         cnt      <= tws_pkg::BIT_CNT_RST;
         sda_oe_n <= 1'b1;
      end else if (stop) begin
         state    <= tws_pkg::ST_IDLE;
         cnt      <= tws_pkg::BIT_CNT_RST;
         sda_oe_n <= 1'b1;
      end else begin
         case (state)
            tws_pkg::ST_ADDR, tws_pkg::ST_REG, tws_pkg::ST_WDATA: begin
               if (rise && cnt != tws_pkg::BIT_CNT_BYTE) begin
                  shift <= {shift[6:0], sda_s};
                  cnt   <= cnt + 4'h1;
               end else if (fall && cnt == tws_pkg::BIT_CNT_BYTE) begin
                  cnt <= tws_pkg::BIT_CNT_RST;
                  if (state == tws_pkg::ST_ADDR) begin
                     if (match) begin
                        state    <= tws_pkg::ST_ACK;
                        sda_oe_n <= 1'b0;
                        if (shift[0] == tws_pkg::DIR_READ) begin
                           ack_next <= tws_pkg::ST_TX;
                           rd_addr  <= reg_ptr;
                           rd_tgl   <= ~rd_tgl;
                        end else begin
                           ack_next <= tws_pkg::ST_REG;
                        end
                     end else begin
                        state <= tws_pkg::ST_IGNORE;
                     end
                  end else if (state == tws_pkg::ST_REG) begin
                     reg_ptr  <= shift;
                     state    <= tws_pkg::ST_ACK;
                     ack_next <= tws_pkg::ST_WDATA;
                     sda_oe_n <= 1'b0;
                  end else begin
                     wr_addr  <= reg_ptr;
                     wr_data  <= shift;
                     wr_tgl   <= ~wr_tgl;
                     reg_ptr  <= reg_ptr + tws_pkg::PTR_STEP;
                     state    <= tws_pkg::ST_ACK;
                     ack_next <= tws_pkg::ST_WDATA;
                     sda_oe_n <= 1'b0;
                  end
               end
            end
            tws_pkg::ST_ACK: begin
               if (fall) begin
                  state <= ack_next;
                  cnt   <= tws_pkg::BIT_CNT_RST;
                  if (ack_next == tws_pkg::ST_TX) begin
                     shift    <= tx_data;
                     sda_oe_n <= tx_data[7];
                  end else begin
                     sda_oe_n <= 1'b1;
                  end
               end
            end
            tws_pkg::ST_TX: begin
               if (fall) begin
                  if (cnt == tws_pkg::BIT_CNT_LAST) begin
                     state    <= tws_pkg::ST_TX_ACK;
                     cnt      <= tws_pkg::BIT_CNT_RST;
                     sda_oe_n <= 1'b1;
                  end else begin
                     shift    <= {shift[6:0], 1'b0};
                     sda_oe_n <= shift[6];
                     cnt      <= cnt + 4'h1;
                  end
               end
            end
            tws_pkg::ST_TX_ACK: begin
               if (rise && cnt == tws_pkg::BIT_CNT_RST) begin
                  if (sda_s) begin
                     state <= tws_pkg::ST_IGNORE;
                  end else begin
                     cnt     <= tws_pkg::BIT_CNT_ACKED;
                     reg_ptr <= reg_ptr + tws_pkg::PTR_STEP;
                     rd_addr <= reg_ptr + tws_pkg::PTR_STEP;
                     rd_tgl  <= ~rd_tgl;
                  end
               end else if (fall && cnt == tws_pkg::BIT_CNT_ACKED) begin
                  state    <= tws_pkg::ST_TX;
                  cnt      <= tws_pkg::BIT_CNT_RST;
                  shift    <= tx_data;
                  sda_oe_n <= tx_data[7];
               end
            end
            default: begin
               sda_oe_n <= 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge link_clk_in or negedge link_rst_n) begin
      if (!link_rst_n) begin
         ack_tgl_q <= 1'b0;
         tx_data   <= tws_pkg::BYTE_RST;
      end else begin
         ack_tgl_q <= ack_tgl_s;
         if (ack_tgl_s != ack_tgl_q) begin
            tx_data <= rd_hold;
         end
      end
   end

   tws_sync #(.W(1)) u_ack_sync (
      .clk_in    (link_clk_in),
      .arst_n_in (link_rst_n),
      .d_in      (rd_ack_tgl),
      .q_out     (ack_tgl_s)
   );

   assign sda_out      = 1'b0;
   assign sda_oe_n_out = sda_oe_n;

   // ------------------------------------------------------------------
   // Core domain: register access strobes
   // ------------------------------------------------------------------
   tws_sync #(.W(2)) u_req_sync (
      .clk_in    (clk_in),
      .arst_n_in (arst_n_in),
      .d_in      ({wr_tgl, rd_tgl}),
      .q_out     (req_s)
   );

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         req_q         <= 2'h0;
         reg_wr_out    <= 1'b0;
         reg_rd_out    <= 1'b0;
         reg_addr_out  <= tws_pkg::BYTE_RST;
         reg_wdata_out <= tws_pkg::BYTE_RST;
      end else begin
         req_q      <= req_s;
         reg_wr_out <= req_s[1] ^ req_q[1];
         reg_rd_out <= (req_s[0] ^ req_q[0]) & ~(req_s[1] ^ req_q[1]);
         if (req_s[1] ^ req_q[1]) begin
            reg_addr_out  <= wr_addr;
            reg_wdata_out <= wr_data;
         end else if (req_s[0] ^ req_q[0]) begin
            reg_addr_out <= rd_addr;
         end
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rd_pending <= 1'b0;
         rd_ack_tgl <= 1'b0;
         rd_hold    <= tws_pkg::BYTE_RST;
      end else begin
         rd_pending <= reg_rd_out;
         if (rd_pending) begin
            rd_hold    <= reg_rdata_in;
            rd_ack_tgl <= ~rd_ack_tgl;
         end
      end
   end

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   property p_addr_ack;
      @(posedge link_clk_in) disable iff (!link_rst_n)
      (state == tws_pkg::ST_ADDR && fall && !start && !stop
       && cnt == tws_pkg::BIT_CNT_BYTE && match)
      |=> (state == tws_pkg::ST_ACK && !sda_oe_n);
   endproperty
   a_addr_ack: assert property (p_addr_ack)
      else $error("matching address not acknowledged");

   property p_mismatch;
      @(posedge link_clk_in) disable iff (!link_rst_n)
      (state == tws_pkg::ST_ADDR && fall && !start && !stop
       && cnt == tws_pkg::BIT_CNT_BYTE && !match)
      |=> (state == tws_pkg::ST_IGNORE && sda_oe_n);
   endproperty
   a_mismatch: assert property (p_mismatch)
      else $error("foreign address not ignored");

   property p_ignore_released;
      @(posedge link_clk_in) disable iff (!link_rst_n)
      (state == tws_pkg::ST_IGNORE) |-> sda_oe_n;
   endproperty
   a_ignore_released: assert property (p_ignore_released)
      else $error("data line driven while ignoring");

   property p_start_abort;
      @(posedge link_clk_in) disable iff (!link_rst_n)
      start |=> (state == tws_pkg::ST_ADDR && cnt == tws_pkg::BIT_CNT_RST
                 && sda_oe_n);
   endproperty
   a_start_abort: assert property (p_start_abort)
      else $error("start did not restart address phase");

   property p_stop_idle;
      @(posedge link_clk_in) disable iff (!link_rst_n)
      stop |=> (state == tws_pkg::ST_IDLE && sda_oe_n);
   endproperty
   a_stop_idle: assert property (p_stop_idle)
      else $error("stop did not return to idle");

   property p_dir;
      @(posedge link_clk_in) disable iff (!link_rst_n)
      ($past(state) == tws_pkg::ST_ADDR && state == tws_pkg::ST_ACK)
      |-> (ack_next == (($past(shift[0]) == tws_pkg::DIR_READ)
                        ? tws_pkg::ST_TX : tws_pkg::ST_REG));
   endproperty
   a_dir: assert property (p_dir)
      else $error("direction bit not honoured");

   property p_tx_bit;
      @(posedge link_clk_in) disable iff (!link_rst_n)
      (state == tws_pkg::ST_TX) |-> (sda_oe_n == shift[7]);
   endproperty
   a_tx_bit: assert property (p_tx_bit)
      else $error("transmitted bit is not the byte MSB");

   property p_sda_low_change;
      @(posedge link_clk_in) disable iff (!link_rst_n)
      $changed(sda_oe_n) |-> (!scl_s || $past(start) || $past(stop));
   endproperty
   a_sda_low_change: assert property (p_sda_low_change)
      else $error("data line changed while clock high");

   property p_wr_pulse;
      @(posedge clk_in) disable iff (!arst_n_in)
      reg_wr_out |=> !reg_wr_out ##1 !reg_wr_out;
   endproperty
   a_wr_pulse: assert property (p_wr_pulse)
      else $error("write strobe longer than one cycle");

   property p_rd_capture;
      @(posedge clk_in) disable iff (!arst_n_in)
      reg_rd_out |-> ##2 (rd_hold == $past(reg_rdata_in, 1)
                          && rd_ack_tgl != $past(rd_ack_tgl, 1));
   endproperty
   a_rd_capture: assert property (p_rd_capture)
      else $error("read data not captured after strobe");

endmodule : tws_slave
`default_nettype wire

// ===== verilog/tws_pkg.sv
`default_nettype none
package tws_pkg;

   // ------------------------------------------------------------------
   // Bus identity and rates
   // ------------------------------------------------------------------
   localparam logic [6:0] SLAVE_ADDR    = 7'h58;
   localparam int         MAX_RATE_KBPS = 100;
   localparam logic       DIR_READ      = 1'b1;

   // ------------------------------------------------------------------
   // Byte framing
   // ------------------------------------------------------------------
   localparam logic [3:0] BIT_CNT_RST   = 4'h0;
   localparam logic [3:0] BIT_CNT_BYTE  = 4'h8;
   localparam logic [3:0] BIT_CNT_LAST  = 4'h7;
   localparam logic [3:0] BIT_CNT_ACKED = 4'h1;

   // ------------------------------------------------------------------
   // Reset values and pointer step
   // ------------------------------------------------------------------
   localparam logic [7:0] BYTE_RST      = 8'h00;
   localparam logic [7:0] PTR_STEP      = 8'h01;

   typedef enum logic [3:0] {
      ST_IDLE   = 4'b0000,
      ST_ADDR   = 4'b0001,
      ST_REG    = 4'b0010,
      ST_WDATA  = 4'b0011,
      ST_ACK    = 4'b0100,
      ST_TX     = 4'b0101,
      ST_TX_ACK = 4'b0110,
      ST_IGNORE = 4'b0111
   } tws_state_t;

endpackage : tws_pkg
`default_nettype wire

// ===== verilog/tws_sync.sv
`timescale 1ns/1ps
`default_nettype none
module tws_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_in,
   input  wire logic         arst_n_in,
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);

   logic [W-1:0] meta;

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         meta  <= '0;
         q_out <= '0;
      end else begin
         meta  <= d_in;
         q_out <= meta;
      end
   end

endmodule : tws_sync
`default_nettype wire

// ===== tb/tws_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module tws_master_model #(
   parameter int QTR = 25
) (
   input  wire logic clk_in,
   input  wire logic sda_in,
   output logic      scl_out,
   output logic      sda_out
);

   // ------------------------------------------------------------------
   // Bus idle and bit timing
   // ------------------------------------------------------------------
   initial begin
      scl_out = 1'b1;
      sda_out = 1'b1;
   end

   task automatic q();
      repeat (QTR) @(negedge clk_in);
   endtask : q

   task automatic start();
      sda_out = 1'b1;
      q();
      scl_out = 1'b1;
      q();
      sda_out = 1'b0;
      q();
      scl_out = 1'b0;
      q();
   endtask : start

   task automatic stop();
      sda_out = 1'b0;
      q();
      scl_out = 1'b1;
      q();
      sda_out = 1'b1;
      q();
   endtask : stop

   task automatic send_bit(input logic v);
      sda_out = v;
      q();
      scl_out = 1'b1;
      q();
      q();
      scl_out = 1'b0;
      q();
   endtask : send_bit

   task automatic wbyte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         send_bit(b[i]);
      end
      sda_out = 1'b1;
      q();
      scl_out = 1'b1;
      q();
      ack = (sda_in === 1'b0);
      q();
      scl_out = 1'b0;
      q();
   endtask : wbyte

   task automatic rbyte(output logic [7:0] b, input logic nack);
      for (int i = 7; i >= 0; i--) begin
         sda_out = 1'b1;
         q();
         scl_out = 1'b1;
         q();
         b[i] = sda_in;
         q();
         scl_out = 1'b0;
         q();
      end
      send_bit(nack);
   endtask : rbyte

endmodule : tws_master_model
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic       clk_in, arst_n_in, link_clk_in, scl, sda_m, sda_bus, watch;
   logic       sda_out, sda_oe_n_out, reg_wr_out, reg_rd_out;
   logic [7:0] reg_addr_out, reg_wdata_out, reg_rdata_in;
   logic [7:0] mem [256];
   int         mismatches, cmp_count, wr_cnt, rd_cnt, cyc, drive_cnt;

   assign sda_bus = sda_m & (sda_oe_n_out ? 1'b1 : sda_out);

   tws_slave dut_u (
      .clk_in        (clk_in),
      .arst_n_in     (arst_n_in),
      .link_clk_in   (link_clk_in),
      .scl_in        (scl),
      .sda_in        (sda_bus),
      .sda_out       (sda_out),
      .sda_oe_n_out  (sda_oe_n_out),
      .reg_wr_out    (reg_wr_out),
      .reg_rd_out    (reg_rd_out),
      .reg_addr_out  (reg_addr_out),
      .reg_wdata_out (reg_wdata_out),
      .reg_rdata_in  (reg_rdata_in)
   );

   tws_master_model master_u (
      .clk_in  (clk_in),
      .sda_in  (sda_bus),
      .scl_out (scl),
      .sda_out (sda_m)
   );

   // ------------------------------------------------------------------
   // Clocks, register file and watchdog
   // ------------------------------------------------------------------
   initial begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end

   initial begin
      link_clk_in = 1'b0;
      #7;
      forever #16 link_clk_in = ~link_clk_in;
   end

   always @(posedge clk_in) begin
      if (reg_wr_out === 1'b1) begin
         mem[reg_addr_out] <= reg_wdata_out;
         wr_cnt++;
      end
      if (reg_rd_out === 1'b1) begin
         rd_cnt++;
      end
      if (watch && sda_oe_n_out !== 1'b1) begin
         drive_cnt++;
      end
      cyc++;
      if (cyc == 40000) begin
         mismatches++;
         summarize();
      end
   end

   always @(negedge clk_in) begin
      reg_rdata_in <= mem[reg_addr_out];
   end

   task automatic check(input string name, input logic [7:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("FAIL %s exp %0h seen %0h", name, exp, seen);
      end
   endtask : check

   task automatic summarize();
      if (mismatches == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : summarize

   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   task automatic do_write(input logic [7:0] r, d, output logic [2:0] a);
      master_u.start();
      master_u.wbyte(8'hB0, a[2]);
      master_u.wbyte(r, a[1]);
      master_u.wbyte(d, a[0]);
      master_u.stop();
   endtask : do_write

   task automatic t_write();
      logic [2:0] a;
      int         w0;
      w0 = wr_cnt;
      do_write(8'h3C, 8'hA5, a);
      check("write acks", {5'h00, a}, 8'h07);
      check("write count", 8'(wr_cnt - w0), 8'h01);
      check("write data", mem[8'h3C], 8'hA5);
      check("write addr", reg_addr_out, 8'h3C);
   endtask : t_write

   task automatic t_read();
      logic [2:0] a;
      logic [7:0] b;
      int         r0;
      mem[8'h12] = 8'h5A;
      r0 = rd_cnt;
      master_u.start();
      master_u.wbyte(8'hB0, a[2]);
      master_u.wbyte(8'h12, a[1]);
      master_u.start();
      master_u.wbyte(8'hB1, a[0]);
      master_u.rbyte(b, 1'b1);
      master_u.stop();
      check("read acks", {5'h00, a}, 8'h07);
      check("read data", b, 8'h5A);
      check("read strobe", 8'(rd_cnt - r0), 8'h01);
   endtask : t_read

   task automatic t_burst();
      logic [3:0] a;
      logic [7:0] b0;
      logic [7:0] b1;
      master_u.start();
      master_u.wbyte(8'hB0, a[3]);
      master_u.wbyte(8'h50, a[2]);
      master_u.wbyte(8'h11, a[1]);
      master_u.wbyte(8'h22, a[0]);
      master_u.stop();
      check("burst wr acks", {4'h0, a}, 8'h0F);
      check("burst wr lo", mem[8'h50], 8'h11);
      check("burst wr hi", mem[8'h51], 8'h22);
      master_u.start();
      master_u.wbyte(8'hB0, a[3]);
      master_u.wbyte(8'h50, a[2]);
      master_u.start();
      master_u.wbyte(8'hB1, a[1]);
      master_u.rbyte(b0, 1'b0);
      master_u.rbyte(b1, 1'b1);
      master_u.stop();
      check("burst rd acks", {5'h00, a[3:1]}, 8'h07);
      check("burst rd lo", b0, 8'h11);
      check("burst rd hi", b1, 8'h22);
   endtask : t_burst

   task automatic t_foreign();
      logic [7:0] adr [2];
      logic       ack, x;
      int         w0;
      adr = '{8'hB2, 8'h31};
      for (int i = 0; i < 2; i++) begin
         w0 = wr_cnt;
         drive_cnt = 0;
         watch = 1'b1;
         master_u.start();
         master_u.wbyte(adr[i], ack);
         master_u.wbyte(8'h00, x);
         master_u.stop();
         watch = 1'b0;
         check("foreign ack", {7'h00, ack}, 8'h00);
         check("foreign drive", 8'(drive_cnt), 8'h00);
         check("foreign write", 8'(wr_cnt - w0), 8'h00);
      end
   endtask : t_foreign

   task automatic t_abort();
      logic [2:0] a;
      int         w0;
      master_u.start();
      for (int i = 0; i < 4; i++) begin
         master_u.send_bit(i[0] ^ 1'b1);
      end
      do_write(8'h40, 8'h33, a);
      check("restart acks", {5'h00, a}, 8'h07);
      check("restart data", mem[8'h40], 8'h33);
      w0 = wr_cnt;
      master_u.start();
      master_u.wbyte(8'hB0, a[2]);
      master_u.wbyte(8'h41, a[1]);
      for (int i = 0; i < 3; i++) begin
         master_u.send_bit(1'b0);
      end
      master_u.stop();
      check("stop abort", 8'(wr_cnt - w0), 8'h00);
   endtask : t_abort

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial begin
      arst_n_in = 1'b0;
      watch = 1'b0;
      for (int i = 0; i < 256; i++) begin
         mem[i] = 8'(~i);
      end
      repeat (6) @(negedge clk_in);
      arst_n_in = 1'b1;
      repeat (10) @(negedge clk_in);
      t_write();
      t_read();
      t_foreign();
      t_abort();
      t_burst();
      summarize();
   end

endmodule : tb
`default_nettype wire
